//--- rtl/shp_pkg.sv
package shp_pkg;

  // ******************************************************************
  // Register addresses
  // ******************************************************************
  localparam logic [31:0] ADDR_PRIO_ONE = 32'hE000ED18;
  localparam logic [31:0] ADDR_PRIO_TWO = 32'hE000ED1C;
  localparam logic [31:0] ADDR_PRIO_THREE = 32'hE000ED20;
  localparam logic [31:0] ADDR_CONTROL = 32'hE000ED24;
  localparam logic [31:0] ADDR_FAULT = 32'hE000ED28;
  localparam logic [31:0] ADDR_BUS_CAUSE = 32'hE000ED29;
  localparam logic [31:0] ADDR_MISUSE_CAUSE = 32'hE000ED2A;

  // ******************************************************************
  // Access sizes and byte lanes
  // ******************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [3:0] LANE_ONE = 4'h1;
  localparam logic [3:0] LANE_LOW_HALF = 4'h3;
  localparam logic [3:0] LANE_HIGH_HALF = 4'hC;
  localparam logic [3:0] LANE_ALL = 4'hF;
  localparam logic [3:0] LANE_NONE = 4'h0;

  // ******************************************************************
  // Implemented bits, everything else reads zero
  // ******************************************************************
  localparam logic [31:0] MASK_PRIO_ONE = 32'h00FFFFFF;
  localparam logic [31:0] MASK_PRIO_TWO = 32'hFF000000;
  localparam logic [31:0] MASK_PRIO_THREE = 32'hFFFF0000;
  localparam logic [31:0] MASK_CONTROL = 32'h0007FD88;
  localparam logic [31:0] MASK_FAULT = 32'h03FF9F9B;
  localparam logic [31:0] RESET_VALUE = 32'h00000000;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int PRI_MEM_PROTECT_LSB = 0;
  localparam int PRI_BUS_ERROR_LSB = 8;
  localparam int PRI_MISUSE_LSB = 16;
  localparam int PRI_SUPERVISOR_CALL_LSB = 24;
  localparam int PRI_DEFERRED_SERVICE_LSB = 16;
  localparam int PRI_SYSTEM_TICK_LSB = 24;
  localparam int PRI_WIDTH = 8;
  localparam int MISUSE_FAULT_ENABLE_BIT = 18;
  localparam int BUS_ERROR_ENABLE_BIT = 17;
  localparam int MEM_PROTECT_ENABLE_BIT = 16;
  localparam int SUPERVISOR_CALL_PENDING_BIT = 15;
  localparam int BUS_ERROR_PENDING_BIT = 14;
  localparam int MEM_PROTECT_PENDING_BIT = 13;
  localparam int MISUSE_FAULT_PENDING_BIT = 12;
  localparam int SYSTEM_TICK_ACTIVE_BIT = 11;
  localparam int DEFERRED_SERVICE_ACTIVE_BIT = 10;
  localparam int DEBUG_MONITOR_ACTIVE_BIT = 8;
  localparam int SUPERVISOR_CALL_ACTIVE_BIT = 7;
  localparam int MISUSE_FAULT_ACTIVE_BIT = 3;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic misuse_fault;
    logic bus_error;
    logic mem_protect;
  } shp_fault_type;

  typedef struct packed {
    logic supervisor_call;
    logic bus_error;
    logic mem_protect;
    logic misuse_fault;
  } shp_pend_type;

  typedef struct packed {
    logic system_tick;
    logic deferred_service;
    logic debug_monitor;
    logic supervisor_call;
    logic misuse_fault;
  } shp_act_type;

  typedef struct packed {
    logic [7:0] system_tick;
    logic [7:0] deferred_service;
    logic [7:0] supervisor_call;
    logic [7:0] misuse;
    logic [7:0] bus_error;
    logic [7:0] mem_protect;
  } shp_prio_type;

endpackage

//--- rtl/shp_handler_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - Each configurable exception holds 8-bit priority
// - Priority registers accept byte reads and writes
// - Register one: memory, bus, misuse priorities
// - Register two: supervisor call priority on top
// - Register three: system tick, deferred service
// - Control enables: misuse 18, bus 17, memory 16
// - Control pending bits fifteen down to twelve
// - Tick active bit 11, deferred bit 10
// - Monitor active bit 8, supervisor bit 7
// - Misuse active bit 3, rest reserved
// - Fault with handler disabled becomes hard fault
// - Writes change pending and active state
// - Word access reaches whole fault cause register
// - Byte at base reaches memory cause byte
// - Halfword at base reaches memory and bus
// - Byte at base plus one reaches bus
// - Halfword at base plus two reaches misuse
module shp_handler_regs (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [31:0] ADDR,
  input wire logic [1:0] SIZE,
  input wire logic [31:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [31:0] RDATA,
  input wire shp_pkg::shp_fault_type FAULT_REQ,
  input wire logic [31:0] FAULT_CAUSE_SET,
  input wire shp_pkg::shp_pend_type PEND_SET,
  input wire shp_pkg::shp_pend_type PEND_CLR,
  input wire shp_pkg::shp_act_type ACT_SET,
  input wire shp_pkg::shp_act_type ACT_CLR,
  output shp_pkg::shp_prio_type PRIORITY,
  output shp_pkg::shp_fault_type HANDLER_ENABLE,
  output shp_pkg::shp_pend_type PENDING,
  output shp_pkg::shp_act_type ACTIVE,
  output logic HARD_FAULT
);
  import shp_pkg::*;

  // ******************************************************************
  // Access decode
  // ******************************************************************
  logic [3:0] lanes;
  logic [31:0] byte_mask;
  logic hit_prio_one;
  logic hit_prio_two;
  logic hit_prio_three;
  logic hit_control;
  logic hit_fault;
  logic [31:0] prio_one;
  logic [31:0] prio_two;
  logic [31:0] prio_three;
  logic [31:0] control;
  logic [31:0] fault_cause;
  logic [31:0] next_control;
  logic [31:0] next_fault_cause;
  logic [31:0] hw_pend_set;
  logic [31:0] hw_pend_clr;
  logic [31:0] hw_act_set;
  logic [31:0] hw_act_clr;
  logic [31:0] read_word;
  logic [2:0] fault_enabled;

  // Misaligned halfword or word gets no lanes and so acts unmapped
  always_comb begin
    lanes = LANE_NONE;
    unique case (SIZE)
      SIZE_BYTE: begin
        lanes = LANE_ONE << ADDR[1:0];
      end
      SIZE_HALF: begin
        if (!ADDR[0]) begin
          lanes = ADDR[1] ? LANE_HIGH_HALF : LANE_LOW_HALF;
        end
      end
      SIZE_WORD: begin
        if (ADDR[1:0] == LANE_NONE[1:0]) begin
          lanes = LANE_ALL;
        end
      end
      default: begin
        lanes = LANE_NONE;
      end
    endcase
  end

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign byte_mask[lane*8 +: 8] = {8{lanes[lane]}};
    end
  endgenerate

  // Whole word select, lanes pick sub-registers
  always_comb begin
    hit_prio_one = ADDR[31:2] == ADDR_PRIO_ONE[31:2];
    hit_prio_two = ADDR[31:2] == ADDR_PRIO_TWO[31:2];
    hit_prio_three = ADDR[31:2] == ADDR_PRIO_THREE[31:2];
    hit_control = ADDR[31:2] == ADDR_CONTROL[31:2];
    hit_fault = ADDR[31:2] == ADDR_FAULT[31:2];
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [31:0] bmask,
                                        input logic [31:0] imask);
    merge = ((old & ~bmask) | (data & bmask)) & imask;
  endfunction

  // ******************************************************************
  // Priority registers
  // ******************************************************************
  // Memory, bus and misuse fields, top byte dropped
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prio_one <= RESET_VALUE;
    end else if (WRITE && hit_prio_one) begin
      prio_one <= merge(prio_one, WDATA, byte_mask, MASK_PRIO_ONE);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prio_two <= RESET_VALUE;
    end else if (WRITE && hit_prio_two) begin
      prio_two <= merge(prio_two, WDATA, byte_mask, MASK_PRIO_TWO);
    end
  end

  // System tick and deferred service fields
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prio_three <= RESET_VALUE;
    end else if (WRITE && hit_prio_three) begin
      prio_three <= merge(prio_three, WDATA, byte_mask, MASK_PRIO_THREE);
    end
  end

  // Eight-bit fields straight from the stores
  assign PRIORITY.mem_protect = prio_one[PRI_MEM_PROTECT_LSB +: PRI_WIDTH];
  assign PRIORITY.bus_error = prio_one[PRI_BUS_ERROR_LSB +: PRI_WIDTH];
  assign PRIORITY.misuse = prio_one[PRI_MISUSE_LSB +: PRI_WIDTH];
  assign PRIORITY.supervisor_call =
    prio_two[PRI_SUPERVISOR_CALL_LSB +: PRI_WIDTH];
  assign PRIORITY.deferred_service =
    prio_three[PRI_DEFERRED_SERVICE_LSB +: PRI_WIDTH];
  assign PRIORITY.system_tick =
    prio_three[PRI_SYSTEM_TICK_LSB +: PRI_WIDTH];

  // ******************************************************************
  // Handler control and state
  // ******************************************************************
  assign fault_enabled = {control[MISUSE_FAULT_ENABLE_BIT],
                          control[BUS_ERROR_ENABLE_BIT],
                          control[MEM_PROTECT_ENABLE_BIT]};

  // Hardware events placed at their register positions
  always_comb begin
    hw_pend_set = RESET_VALUE;
    hw_pend_clr = RESET_VALUE;
    hw_act_set = RESET_VALUE;
    hw_act_clr = RESET_VALUE;
    // Enabled faults and calls become pending
    hw_pend_set[SUPERVISOR_CALL_PENDING_BIT] = PEND_SET.supervisor_call;
    hw_pend_set[BUS_ERROR_PENDING_BIT] = PEND_SET.bus_error |
      (FAULT_REQ.bus_error & fault_enabled[1]);
    hw_pend_set[MEM_PROTECT_PENDING_BIT] = PEND_SET.mem_protect |
      (FAULT_REQ.mem_protect & fault_enabled[0]);
    hw_pend_set[MISUSE_FAULT_PENDING_BIT] = PEND_SET.misuse_fault |
      (FAULT_REQ.misuse_fault & fault_enabled[2]);
    hw_pend_clr[SUPERVISOR_CALL_PENDING_BIT] = PEND_CLR.supervisor_call;
    hw_pend_clr[BUS_ERROR_PENDING_BIT] = PEND_CLR.bus_error;
    hw_pend_clr[MEM_PROTECT_PENDING_BIT] = PEND_CLR.mem_protect;
    hw_pend_clr[MISUSE_FAULT_PENDING_BIT] = PEND_CLR.misuse_fault;
    hw_act_set[SYSTEM_TICK_ACTIVE_BIT] = ACT_SET.system_tick;
    hw_act_set[DEFERRED_SERVICE_ACTIVE_BIT] = ACT_SET.deferred_service;
    hw_act_set[DEBUG_MONITOR_ACTIVE_BIT] = ACT_SET.debug_monitor;
    hw_act_set[SUPERVISOR_CALL_ACTIVE_BIT] = ACT_SET.supervisor_call;
    hw_act_set[MISUSE_FAULT_ACTIVE_BIT] = ACT_SET.misuse_fault;
    hw_act_clr[SYSTEM_TICK_ACTIVE_BIT] = ACT_CLR.system_tick;
    hw_act_clr[DEFERRED_SERVICE_ACTIVE_BIT] = ACT_CLR.deferred_service;
    hw_act_clr[DEBUG_MONITOR_ACTIVE_BIT] = ACT_CLR.debug_monitor;
    hw_act_clr[SUPERVISOR_CALL_ACTIVE_BIT] = ACT_CLR.supervisor_call;
    hw_act_clr[MISUSE_FAULT_ACTIVE_BIT] = ACT_CLR.misuse_fault;
  end

  // Hardware sets win over both software and hardware clears
  always_comb begin
    next_control = control;
    // Software rewrites enable, pending and active
    if (WRITE && hit_control) begin
      next_control = merge(control, WDATA, byte_mask, MASK_CONTROL);
    end
    next_control = next_control & ~(hw_pend_clr | hw_act_clr);
    next_control = (next_control | hw_pend_set | hw_act_set) & MASK_CONTROL;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      control <= RESET_VALUE;
    end else begin
      control <= next_control;
    end
  end

  assign HANDLER_ENABLE = fault_enabled;
  assign PENDING = {control[SUPERVISOR_CALL_PENDING_BIT],
                    control[BUS_ERROR_PENDING_BIT],
                    control[MEM_PROTECT_PENDING_BIT],
                    control[MISUSE_FAULT_PENDING_BIT]};
  assign ACTIVE = {control[SYSTEM_TICK_ACTIVE_BIT],
                   control[DEFERRED_SERVICE_ACTIVE_BIT],
                   control[DEBUG_MONITOR_ACTIVE_BIT],
                   control[SUPERVISOR_CALL_ACTIVE_BIT],
                   control[MISUSE_FAULT_ACTIVE_BIT]};

  // Disabled handler escalates to hard fault
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      HARD_FAULT <= 1'b0;
    end else begin
      HARD_FAULT <= |(FAULT_REQ & ~fault_enabled);
    end
  end

  // ******************************************************************
  // Fault cause register
  // ******************************************************************
  // Write one clears; a cause arriving in the same cycle survives
  always_comb begin
    next_fault_cause = fault_cause;
    // Lanes confine the clear to addressed bytes
    if (WRITE && hit_fault) begin
      next_fault_cause = fault_cause & ~(WDATA & byte_mask);
    end
    next_fault_cause = (next_fault_cause | FAULT_CAUSE_SET) & MASK_FAULT;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fault_cause <= RESET_VALUE;
    end else begin
      fault_cause <= next_fault_cause;
    end
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  always_comb begin
    read_word = RESET_VALUE;
    if (hit_prio_one) begin
      read_word = prio_one;
    end else if (hit_prio_two) begin
      read_word = prio_two;
    end else if (hit_prio_three) begin
      read_word = prio_three;
    end else if (hit_control) begin
      read_word = control;
    end else if (hit_fault) begin
      // Halfword at base shows memory and bus bytes
      // Byte at plus one shows bus byte
      // Halfword at plus two shows misuse half
      read_word = fault_cause;
    end
  end

  // Data stays in its byte lanes; unused lanes read zero
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= RESET_VALUE;
    end else if (READ) begin
      RDATA <= read_word & byte_mask;
    end else begin
      RDATA <= RESET_VALUE;
    end
  end

endmodule

//--- tb/shp_handler_regs_asserts.sv
`timescale 1ns/10ps
module shp_handler_asserts (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WRITE,
  input wire logic READ,
  input wire logic [1:0] SIZE,
  input wire shp_pkg::shp_fault_type FAULT_REQ,
  input wire shp_pkg::shp_pend_type PEND_SET,
  input wire shp_pkg::shp_pend_type PEND_CLR,
  input wire shp_pkg::shp_act_type ACT_SET,
  input wire shp_pkg::shp_prio_type PRIORITY,
  input wire shp_pkg::shp_fault_type HANDLER_ENABLE,
  input wire shp_pkg::shp_pend_type PENDING,
  input wire shp_pkg::shp_act_type ACTIVE,
  input wire logic [31:0] RDATA,
  input wire logic HARD_FAULT
);
  import shp_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ****
  // Fault events
  // ****
  fault_escalate_a: assert property (
    (FAULT_REQ & ~HANDLER_ENABLE) != 3'h0 |=> HARD_FAULT)
    else $error("disabled fault not escalated");
  hard_fault_cause_a: assert property (
    HARD_FAULT |-> ($past(FAULT_REQ) & ~$past(HANDLER_ENABLE)) != 3'h0)
    else $error("hard fault without cause");
  fault_pends_a: assert property (
    FAULT_REQ.bus_error && HANDLER_ENABLE.bus_error |=> PENDING.bus_error)
    else $error("enabled fault not pending");
  // ****
  // State bits
  // ****
  enable_sw_only_a: assert property (
    !WRITE |=> $stable(HANDLER_ENABLE))
    else $error("enable changed without write");
  prio_sw_only_a: assert property (
    !WRITE |=> $stable(PRIORITY))
    else $error("priority changed without write");
  pend_set_a: assert property (
    PEND_SET != 4'h0 |=> (PENDING & $past(PEND_SET)) == $past(PEND_SET))
    else $error("pending set lost");
  act_set_a: assert property (
    ACT_SET != 5'h00 |=> (ACTIVE & $past(ACT_SET)) == $past(ACT_SET))
    else $error("active set lost");
  rdata_idle_a: assert property (
    !READ |=> RDATA == 32'h0)
    else $error("read data outside read cycle");
  pend_hold_a: assert property (
    PEND_CLR == 4'h0 && !WRITE |=>
    (PENDING & $past(PENDING)) == $past(PENDING))
    else $error("pending dropped on its own");
  cover property (HARD_FAULT);
  cover property (READ && SIZE == SIZE_BYTE);
  cover property (WRITE && SIZE == SIZE_HALF);
endmodule
bind shp_handler_regs shp_handler_asserts shp_handler_asserts_inst (
  .CLK(CLK), .RST_B(RST_B), .WRITE(WRITE), .READ(READ), .SIZE(SIZE),
  .FAULT_REQ(FAULT_REQ), .PEND_SET(PEND_SET), .PEND_CLR(PEND_CLR),
  .ACT_SET(ACT_SET), .PRIORITY(PRIORITY), .HANDLER_ENABLE(HANDLER_ENABLE),
  .PENDING(PENDING), .ACTIVE(ACTIVE), .RDATA(RDATA),
  .HARD_FAULT(HARD_FAULT));

//--- tb/shp_core_model.sv
`timescale 1ns/10ps
module shp_core_model (
  input wire logic CLK,
  output logic [31:0] ADDR,
  output logic [1:0] SIZE,
  output logic [31:0] WDATA,
  output logic WRITE,
  output logic READ,
  input wire logic [31:0] RDATA
);
  import shp_pkg::*;
  initial begin
    ADDR = 32'h0;
    SIZE = 2'h3;
    WDATA = 32'h0;
    WRITE = 1'b0;
    READ = 1'b0;
  end
  task automatic wr(input logic [31:0] a, input logic [1:0] s,
                    input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    SIZE <= s;
    WDATA <= d;
    WRITE <= 1'b1;
    @(posedge CLK);
    WRITE <= 1'b0;
    SIZE <= 2'h3;
    // Released data inverted so stale values cannot pass
    WDATA <= ~d;
    // Let the write settle before callers look at outputs
    #1;
  endtask
  task automatic rd(input logic [31:0] a, input logic [1:0] s,
                    output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    SIZE <= s;
    READ <= 1'b1;
    @(posedge CLK);
    READ <= 1'b0;
    SIZE <= 2'h3;
    #1;
    d = RDATA;
  endtask
  task automatic rmw(input logic [31:0] a, input logic [31:0] m);
    logic [31:0] v;
    rd(a, SIZE_WORD, v);
    wr(a, SIZE_WORD, v | m);
  endtask
endmodule

//--- tb/tb_shp_handler_regs.sv
`timescale 1ns/10ps
`define CHK(g, x) begin \
  checked++; \
  if ((g) !== (x)) begin \
    n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x); \
  end \
end
module tb_shp_handler_regs;
  import shp_pkg::*;
  logic clk, rst_b, write, read, hard_fault;
  logic [1:0] size;
  logic [31:0] addr, wdata, rdata, cause_set, v;
  shp_fault_type fault_req, hen;
  shp_pend_type pend_set, pend_clr, pend;
  shp_act_type act_set, act_clr, act;
  shp_prio_type prio;
  logic [31:0] msk [3] = '{MASK_PRIO_ONE, MASK_PRIO_TWO, MASK_PRIO_THREE};
  int n_fail = 0;
  int checked = 0;
  int i;
  shp_core_model shp_core_model_inst (.CLK(clk), .ADDR(addr), .SIZE(size),
    .WDATA(wdata), .WRITE(write), .READ(read), .RDATA(rdata));
  shp_handler_regs shp_handler_regs_inst (.CLK(clk), .RST_B(rst_b),
    .ADDR(addr), .SIZE(size), .WDATA(wdata), .WRITE(write), .READ(read),
    .RDATA(rdata), .FAULT_REQ(fault_req), .FAULT_CAUSE_SET(cause_set),
    .PEND_SET(pend_set), .PEND_CLR(pend_clr), .ACT_SET(act_set),
    .ACT_CLR(act_clr), .PRIORITY(prio), .HANDLER_ENABLE(hen),
    .PENDING(pend), .ACTIVE(act), .HARD_FAULT(hard_fault));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wr(input logic [31:0] a, input logic [1:0] s,
                    input logic [31:0] d);
    shp_core_model_inst.wr(a, s, d);
  endtask
  task automatic rc(input logic [31:0] a, input logic [1:0] s,
                    input logic [31:0] x);
    logic [31:0] d;
    shp_core_model_inst.rd(a, s, d);
    `CHK(d, x);
  endtask
  task automatic ev(input shp_fault_type f, input logic [31:0] c,
                    input shp_pend_type ps, input shp_pend_type pc,
                    input shp_act_type as, input shp_act_type ac);
    @(posedge clk);
    fault_req <= f;
    cause_set <= c;
    pend_set <= ps;
    pend_clr <= pc;
    act_set <= as;
    act_clr <= ac;
    @(posedge clk);
    fault_req <= '0;
    cause_set <= '0;
    pend_set <= '0;
    pend_clr <= '0;
    act_set <= '0;
    act_clr <= '0;
    #1;
  endtask
  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    end_sim;
  end
  initial begin
    rst_b = 1'b0;
    fault_req = '0;
    cause_set = '0;
    pend_set = '0;
    pend_clr = '0;
    act_set = '0;
    act_clr = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rc(ADDR_PRIO_ONE + 4 * i, SIZE_WORD, RESET_VALUE);
    end
    rc(32'hE000ED30, SIZE_WORD, 32'h0);
    $display("test reset done");
    for (i = 0; i < 12; i++) begin
      wr(ADDR_PRIO_ONE + i, SIZE_BYTE, 32'(255 - i) << (8 * (i % 4)));
    end
    for (i = 0; i < 3; i++) begin
      v = {8'(252 - 4 * i), 8'(253 - 4 * i), 8'(254 - 4 * i), 8'(255 - 4 * i)};
      rc(ADDR_PRIO_ONE + 4 * i, SIZE_WORD, v & msk[i]);
    end
    rc(ADDR_PRIO_ONE + 1, SIZE_BYTE, 32'h0000FE00);
    `CHK(prio, {8'hF4, 8'hF5, 8'hF8, 8'hFD, 8'hFE, 8'hFF});
    $display("test priority done");
    wr(ADDR_CONTROL, SIZE_WORD, 32'hFFFFFFFF);
    rc(ADDR_CONTROL, SIZE_WORD, MASK_CONTROL);
    `CHK({hen, pend, act}, 12'hFFF);
    wr(ADDR_CONTROL, SIZE_WORD, 32'h0);
    rc(ADDR_CONTROL, SIZE_WORD, 32'h0);
    for (i = 0; i < 3; i++) begin
      ev(3'(1 << i), '0, '0, '0, '0, '0);
      `CHK(hard_fault, 1'b1);
    end
    shp_core_model_inst.rmw(ADDR_CONTROL, 32'h00070000);
    for (i = 0; i < 3; i++) begin
      ev(3'(1 << i), '0, '0, '0, '0, '0);
      `CHK(hard_fault, 1'b0);
    end
    rc(ADDR_CONTROL, SIZE_WORD, 32'h00077000);
    $display("test escalation done");
    ev('0, '0, 4'h8, '0, 5'h1F, '0);
    `CHK({pend, act}, 9'h1FF);
    shp_core_model_inst.rd(ADDR_CONTROL, SIZE_WORD, v);
    wr(ADDR_CONTROL, SIZE_WORD, v & ~32'h00000D88);
    `CHK(act, 5'h00);
    wr(ADDR_CONTROL, SIZE_WORD, v);
    `CHK(act, 5'h1F);
    ev('0, '0, '0, 4'hF, '0, 5'h1F);
    `CHK({pend, act}, 9'h000);
    $display("test state done");
    ev('0, 32'hFFFFFFFF, '0, '0, '0, '0);
    rc(ADDR_FAULT, SIZE_WORD, MASK_FAULT);
    rc(ADDR_FAULT, SIZE_BYTE, MASK_FAULT & 32'h000000FF);
    rc(ADDR_FAULT, SIZE_HALF, MASK_FAULT & 32'h0000FFFF);
    rc(ADDR_BUS_CAUSE, SIZE_BYTE, MASK_FAULT & 32'h0000FF00);
    rc(ADDR_MISUSE_CAUSE, SIZE_HALF, MASK_FAULT & 32'hFFFF0000);
    rc(ADDR_MISUSE_CAUSE, SIZE_WORD, 32'h0);
    wr(ADDR_BUS_CAUSE, SIZE_BYTE, 32'hFFFFFFFF);
    rc(ADDR_FAULT, SIZE_WORD, MASK_FAULT & 32'hFFFF00FF);
    wr(ADDR_MISUSE_CAUSE, SIZE_HALF, 32'hFFFFFFFF);
    rc(ADDR_FAULT, SIZE_WORD, MASK_FAULT & 32'h000000FF);
    wr(ADDR_FAULT, SIZE_BYTE, 32'hFFFFFFFF);
    rc(ADDR_FAULT, SIZE_WORD, 32'h0);
    ev('0, 32'hFFFFFFFF, '0, '0, '0, '0);
    wr(ADDR_FAULT, SIZE_HALF, 32'hFFFFFFFF);
    rc(ADDR_FAULT, SIZE_WORD, MASK_FAULT & 32'hFFFF0000);
    wr(ADDR_FAULT, SIZE_WORD, 32'hFFFFFFFF);
    rc(ADDR_FAULT, SIZE_WORD, 32'h0);
    $display("test fault cause done");
    end_sim;
  end
endmodule
